//--- design/sxr_core.sv
`timescale 1ns/10ps
// Functional notes
// - sequence exit when selected input reaches target
// - sequence delay programmable 10us to 400ms
// - delay needs stable input; change restarts timer
// - monitor exit is wide OR of deviations
// - monitor exit has no delay
// - about 20us load latency per transition
// - timeout exit after 100us to 400ms
// - driver outputs fixed per state
// - fault latch bits stay set
// - fault latching enabled per state
// - host reads fault latch registers
// - live status registers follow inputs
// - snapshot status held per state change
// - record region 0xf980 to 0xf9ff, 16 slots
// - record-write state entry writes one record if recorder ready
// - record: flag, state, cause, status, checksum
// - eight bytes, 250us each
// - finish record before starting another
// - power-on scan for first flag-one slot
// - program only, stop when full
// - 63 states, three exit routes
// - warnings ORed into one detector input
// - host jump forces advance
module sxr_core
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 clk_en,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // supply fault detector and warning pins
  input  wire logic [9:0]           supply_fault_detector_uv,
  input  wire logic [9:0]           supply_fault_detector_ov,
  input  wire logic [9:0]           adc_limit_warn,
  input  wire logic                 secondary_warn,
  // driver outputs
  output logic      [9:0]           driver_output_pin,
  // nonvolatile memory port
  output logic                      nv_rd,
  output logic                      nv_wr,
  output logic      [15:0]          nv_addr,
  output logic      [7:0]           nv_wdata,
  input  wire logic [7:0]           nv_rdata,
  input  wire logic                 nv_rvalid
);
  import sxr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [30:0] sync1_reg;
  logic [30:0] sync2_reg;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg <= 31'h0;
      sync2_reg <= 31'h0;
    end
    else if (clk_en)
    begin
      sync1_reg <= {secondary_warn, adc_limit_warn,
                    supply_fault_detector_ov, supply_fault_detector_uv};
      sync2_reg <= sync1_reg;
    end
  end

  logic [9:0] uv_s;
  logic [9:0] ov_s;
  logic [9:0] lim_s;
  logic       warn;
  assign uv_s  = sync2_reg[9:0];
  assign ov_s  = sync2_reg[19:10];
  assign lim_s = sync2_reg[29:20];
  assign warn  = (|lim_s) | sync2_reg[30];

  //////////////////////////////////////////////////////////////////////////////
  // state definition memory, loaded by host
  sxr_cfg0_type cfg0_mem [NUM_STATES];
  sxr_cfg1_type cfg1_mem [NUM_STATES];
  sxr_cfg2_type cfg2_mem [NUM_STATES];
  sxr_cfg0_type cfg0_reg;
  sxr_cfg1_type cfg1_reg;
  sxr_cfg2_type cfg2_reg;
  logic [5:0]   cfg_sel_reg;
  logic [31:0]  ctrl_reg;
  logic         wr_en;
  logic         rd_en;
  assign wr_en = psel & penable & pwrite & clk_en;
  assign rd_en = psel & ~penable & ~pwrite & clk_en;

  // bit 31 of a select write also sets both delays of that state
  always_ff @(posedge ref_clk)
  begin
    if (wr_en && paddr == ADDR_CFG_W0 && cfg_sel_reg < 6'(NUM_STATES))
      cfg0_mem[cfg_sel_reg] <= sxr_cfg0_type'(pwdata);
    if (wr_en && paddr == ADDR_CFG_W1 && cfg_sel_reg < 6'(NUM_STATES))
      cfg1_mem[cfg_sel_reg] <= sxr_cfg1_type'(pwdata);
    if (wr_en && paddr == ADDR_CFG_SEL && pwdata[31] && pwdata[25:20] < 6'(NUM_STATES))
      cfg2_mem[pwdata[25:20]] <= sxr_cfg2_type'({pwdata[18:0], pwdata[18:0]});
  end

  //////////////////////////////////////////////////////////////////////////////
  // state machine core
  sxr_se_state_type se_reg;
  logic [5:0]       cur_state_reg;
  logic [5:0]       next_state_reg;
  logic [15:0]      load_cnt_reg;
  logic [5:0]       us_cnt_reg;
  logic [18:0]      seq_us_reg;
  logic [18:0]      tmo_us_reg;
  logic             seq_last_reg;
  logic [1:0]       cause_reg;
  logic             jump_req;
  logic             us_tick;
  logic [11:0]      se_in;
  logic             seq_in;
  logic             seq_hit;
  logic             tmo_hit;
  logic             mon_hit;
  logic [9:0]       dev;

  assign us_tick = (us_cnt_reg == 6'(US_TICK_CYC - 1));
  assign jump_req = wr_en && paddr == ADDR_CTRL && pwdata[CTRL_JUMP_BIT];
  assign se_in = {jump_req, warn, uv_s};
  assign seq_in = se_in[cfg0_reg.seq_sel];
  // deviation: expected low means ok when not uv, flagged on uv or ov
  assign dev = (uv_s ^ cfg1_reg.mon_expect_hi) | ov_s;
  assign mon_hit = |({1'b0, warn, dev} & cfg1_reg.mon_mask);
  assign tmo_hit = (cfg0_reg.tmo_en && tmo_us_reg >= cfg2_reg.tmo_delay_us)
                   || jump_req;
  assign seq_hit = (seq_in == cfg0_reg.seq_level &&
                    seq_us_reg >= cfg2_reg.seq_delay_us) || jump_req;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      us_cnt_reg <= 6'h0;
    else if (clk_en)
      us_cnt_reg <= us_tick ? 6'h0 : us_cnt_reg + 6'h1;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      se_reg         <= SXR_IDLE;
      cur_state_reg  <= START_STATE;
      next_state_reg <= START_STATE;
      load_cnt_reg   <= 16'h0;
      cause_reg      <= EXIT_NONE;
    end
    else if (clk_en)
    begin
      unique case (se_reg)
        SXR_IDLE:
          if (ctrl_reg[CTRL_RUN_BIT])
          begin
            se_reg       <= SXR_LOAD;
            load_cnt_reg <= 16'h0;
          end
        SXR_LOAD:
          if (load_cnt_reg == 16'(LOAD_CYC - 1))
          begin
            se_reg        <= SXR_RUN;
            cur_state_reg <= next_state_reg;
          end
          else
            load_cnt_reg <= load_cnt_reg + 16'h1;
        SXR_RUN:
          // fixed priority on coincident exits
          if (mon_hit)
          begin
            next_state_reg <= cfg0_reg.mon_next;
            cause_reg      <= EXIT_MON;
            se_reg         <= SXR_HOLD;
          end
          else if (tmo_hit && cfg0_reg.tmo_en)
          begin
            next_state_reg <= cfg0_reg.tmo_next;
            cause_reg      <= EXIT_TMO;
            se_reg         <= SXR_HOLD;
          end
          else if (seq_hit)
          begin
            next_state_reg <= cfg0_reg.seq_next;
            cause_reg      <= EXIT_SEQ;
            se_reg         <= SXR_HOLD;
          end
        SXR_HOLD:
        begin
          se_reg       <= SXR_LOAD;
          load_cnt_reg <= 16'h0;
        end
      endcase
    end
  end

  // configuration of the entered state; illegal indices clamp to last
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg0_reg <= '0;
      cfg1_reg <= '0;
      cfg2_reg <= '0;
    end
    else if (clk_en && se_reg == SXR_LOAD && load_cnt_reg == 16'h0)
    begin
      cfg0_reg <= cfg0_mem[next_state_reg < 6'(NUM_STATES) ? next_state_reg : 6'h3e];
      cfg1_reg <= cfg1_mem[next_state_reg < 6'(NUM_STATES) ? next_state_reg : 6'h3e];
      cfg2_reg <= cfg2_mem[next_state_reg < 6'(NUM_STATES) ? next_state_reg : 6'h3e];
    end
  end

  // detector timers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seq_us_reg   <= 19'h0;
      tmo_us_reg   <= 19'h0;
      seq_last_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      seq_last_reg <= seq_in;
      if (se_reg != SXR_RUN)
      begin
        seq_us_reg <= 19'h0;
        tmo_us_reg <= 19'h0;
      end
      else
      begin
        if (seq_in != cfg0_reg.seq_level || seq_in != seq_last_reg)
          seq_us_reg <= 19'h0;
        else if (us_tick && seq_us_reg != 19'h7ffff)
          seq_us_reg <= seq_us_reg + 19'h1;
        if (us_tick && tmo_us_reg != 19'h7ffff)
          tmo_us_reg <= tmo_us_reg + 19'h1;
      end
    end
  end

  // outputs held for the whole state
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      driver_output_pin <= 10'h0;
    else if (clk_en && se_reg == SXR_LOAD && load_cnt_reg == 16'(LOAD_CYC - 1))
      driver_output_pin <= cfg1_reg.drv_level;
  end

  //////////////////////////////////////////////////////////////////////////////
  // fault latch and status snapshot
  logic [9:0]     fault_reg;
  sxr_status_type snap_reg;
  logic [5:0]     prev_state_reg;
  logic [1:0]     prev_cause_reg;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      fault_reg <= 10'h0;
    else if (clk_en)
    begin
      // set wins over host clear
      if (wr_en && paddr == ADDR_CTRL && pwdata[CTRL_FCLR_BIT])
        fault_reg <= (se_reg == SXR_RUN && cfg0_reg.flt_latch_en) ? (dev | ov_s) : 10'h0;
      else if (se_reg == SXR_RUN && cfg0_reg.flt_latch_en)
        fault_reg <= fault_reg | dev | ov_s;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      snap_reg       <= '0;
      prev_state_reg <= 6'h0;
      prev_cause_reg <= EXIT_NONE;
    end
    else if (clk_en && se_reg == SXR_HOLD)
    begin
      snap_reg       <= '{uv: uv_s, ov: ov_s, gpi: uv_s[9:5], lim: lim_s};
      prev_state_reg <= cur_state_reg;
      prev_cause_reg <= cause_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // black box recorder
  sxr_rec_state_type rec_reg;
  logic [3:0]   slot_reg;
  logic [2:0]   byte_reg;
  logic [13:0]  prog_cnt_reg;
  logic         pend_reg;
  logic [7:0]   sum_reg;
  logic [7:0]   rec_byte;
  logic [63:0]  rec_img;
  logic         rec_rst;

  function automatic logic [15:0] slot_addr(input logic [3:0] s, input logic [2:0] b);
    slot_addr = REC_BASE + {9'h0, s, b};
  endfunction

  assign rec_rst = wr_en && paddr == ADDR_CTRL && pwdata[CTRL_RECRST_BIT];
  // byte0: bit7 used flag (0 once written), 1 cause (bit 0), 6 state
  assign rec_img = {1'b0, prev_cause_reg[0], prev_state_reg,
                    snap_reg.uv[7:0], snap_reg.ov[7:0],
                    snap_reg.uv[9:8], snap_reg.ov[9:8], snap_reg.lim[9:8], prev_cause_reg,
                    3'h0, snap_reg.gpi, snap_reg.lim[7:0], 8'h00, 8'h00};
  assign rec_byte = (byte_reg == 3'h7) ? sum_reg : rec_img[63 - 8 * byte_reg -: 8];

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rec_reg      <= REC_SCAN;
      slot_reg     <= 4'h0;
      byte_reg     <= 3'h0;
      prog_cnt_reg <= 14'h0;
      pend_reg     <= 1'b0;
      sum_reg      <= 8'h0;
      nv_rd        <= 1'b0;
      nv_wr        <= 1'b0;
      nv_addr      <= 16'h0;
      nv_wdata     <= 8'h0;
    end
    else if (clk_en)
    begin
      nv_rd <= 1'b0;
      nv_wr <= 1'b0;
      // entry to a record-write state
      if (se_reg == SXR_LOAD && load_cnt_reg == 16'(LOAD_CYC - 1) && cfg0_reg.rec_write)
        pend_reg <= (rec_reg == REC_READY);
      if (rec_rst)
      begin
        rec_reg  <= REC_SCAN;
        slot_reg <= 4'h0;
        pend_reg <= 1'b0;
        nv_addr  <= 16'h0;
      end
      else
        unique case (rec_reg)
          REC_SCAN:
            if (nv_rvalid)
            begin
              if (nv_rdata[7])
                rec_reg <= REC_READY;
              else if (slot_reg == 4'(REC_SLOTS - 1))
                rec_reg <= REC_FULL;
              else
                slot_reg <= slot_reg + 4'h1;
            end
            else if (nv_addr != slot_addr(slot_reg, 3'h0)) // one read in flight per slot
            begin
              nv_rd   <= 1'b1;
              nv_addr <= slot_addr(slot_reg, 3'h0);
            end
          REC_READY:
            if (pend_reg)
            begin
              pend_reg     <= 1'b0;
              rec_reg      <= REC_PROG;
              byte_reg     <= 3'h0;
              prog_cnt_reg <= 14'h0;
              sum_reg      <= 8'h0;
            end
          REC_PROG:
          begin
            if (prog_cnt_reg == 14'h0)
            begin
              nv_wr    <= 1'b1;
              nv_addr  <= slot_addr(slot_reg, byte_reg);
              nv_wdata <= rec_byte;
              sum_reg  <= sum_reg + rec_byte;
            end
            if (prog_cnt_reg == 14'(BYTE_PROG_CYC - 1))
            begin
              prog_cnt_reg <= 14'h0;
              byte_reg     <= byte_reg + 3'h1;
              if (byte_reg == 3'(RECORD_BYTES - 1))
                if (slot_reg == 4'(REC_SLOTS - 1))
                  rec_reg <= REC_FULL;
                else
                begin
                  slot_reg <= slot_reg + 4'h1;
                  rec_reg  <= REC_READY;
                end
            end
            else
              prog_cnt_reg <= prog_cnt_reg + 14'h1;
          end
          REC_FULL:
            pend_reg <= 1'b0;
        endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, unmapped reads zero and error
  logic mapped;
  assign mapped = paddr inside {ADDR_CTRL, ADDR_STATE, ADDR_FLT_LOW, ADDR_FLT_HIGH,
                  ADDR_UV_STATUS, ADDR_OV_STATUS, ADDR_LOGIC_STAT, ADDR_LIM_STATUS,
                  ADDR_SNAP0, ADDR_SNAP1, ADDR_REC_STAT, ADDR_CFG_SEL,
                  ADDR_CFG_W0, ADDR_CFG_W1};

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg    <= 32'h0;
      cfg_sel_reg <= 6'h0;
    end
    else if (wr_en)
    begin
      if (paddr == ADDR_CTRL)
        ctrl_reg <= {28'h0, pwdata[CTRL_RUN_BIT], 3'h0}; // action bits self clear
      if (paddr == ADDR_CFG_SEL)
        cfg_sel_reg <= pwdata[25:20];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (rd_en)
        unique case (paddr)
          ADDR_CTRL:       prdata <= ctrl_reg;
          ADDR_STATE:      prdata <= {16'h0, 4'(se_reg), cur_state_reg, 6'(next_state_reg)};
          ADDR_FLT_LOW:    prdata <= {24'h0, fault_reg[7:0]};
          ADDR_FLT_HIGH:   prdata <= {30'h0, fault_reg[9:8]};
          ADDR_UV_STATUS:  prdata <= {22'h0, uv_s};
          ADDR_OV_STATUS:  prdata <= {22'h0, ov_s};
          ADDR_LOGIC_STAT: prdata <= {27'h0, uv_s[9:5]};
          ADDR_LIM_STATUS: prdata <= {22'h0, lim_s};
          ADDR_SNAP0:      prdata <= {12'h0, snap_reg.uv, snap_reg.ov};
          ADDR_SNAP1:      prdata <= {9'h0, prev_cause_reg, prev_state_reg, snap_reg.gpi,
                                      snap_reg.lim};
          ADDR_REC_STAT:   prdata <= {24'h0, 4'(rec_reg), slot_reg};
          ADDR_CFG_SEL:    prdata <= {26'h0, cfg_sel_reg};
          default:         prdata <= 32'h0;
        endcase
    end
  end
endmodule // sxr_core

//--- design/sxr_pkg.sv
package sxr_pkg;
  // clock 40 MHz
  localparam int unsigned CLK_MHZ = 40;
  // times in microseconds (RECORD_PROG_MS in ms, *_CYC in clock cycles)
  localparam int unsigned SEQ_DELAY_MIN_US   = 10;
  localparam int unsigned SEQ_DELAY_MAX_US   = 400000;
  localparam int unsigned TMO_DELAY_MIN_US   = 100;
  localparam int unsigned TMO_DELAY_MAX_US   = 400000;
  localparam int unsigned LOAD_LATENCY_US    = 20;
  localparam int unsigned BYTE_PROG_US       = 250;
  localparam int unsigned RECORD_PROG_MS     = 2;
  localparam int unsigned US_TICK_CYC        = CLK_MHZ;
  localparam int unsigned LOAD_CYC           = LOAD_LATENCY_US * CLK_MHZ;
  localparam int unsigned BYTE_PROG_CYC      = BYTE_PROG_US * CLK_MHZ;
  localparam int unsigned RECORD_BYTES       = 8;

  // record region
  localparam logic [15:0] USER_NV_BASE  = 16'hf900;
  localparam logic [15:0] USER_NV_LAST  = 16'hf9ff;
  localparam logic [15:0] REC_BASE      = 16'hf980;
  localparam logic [15:0] REC_LAST_SLOT = 16'hf9f8;
  localparam int unsigned REC_SLOTS     = 16;

  localparam int unsigned NUM_INPUTS  = 10;
  localparam int unsigned NUM_OUTPUTS = 10;
  localparam int unsigned NUM_STATES  = 63;
  localparam int unsigned SE_INPUTS   = 12;   // 10 supply, warning, host jump

  // register map, byte addresses
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_STATE      = 12'h004;
  localparam logic [11:0] ADDR_FLT_LOW    = 12'h008;
  localparam logic [11:0] ADDR_FLT_HIGH   = 12'h00c;
  localparam logic [11:0] ADDR_UV_STATUS  = 12'h010;
  localparam logic [11:0] ADDR_OV_STATUS  = 12'h014;
  localparam logic [11:0] ADDR_LOGIC_STAT = 12'h018;
  localparam logic [11:0] ADDR_LIM_STATUS = 12'h01c;
  localparam logic [11:0] ADDR_SNAP0      = 12'h020;
  localparam logic [11:0] ADDR_SNAP1      = 12'h024;
  localparam logic [11:0] ADDR_REC_STAT   = 12'h028;
  localparam logic [11:0] ADDR_CFG_SEL    = 12'h030;
  localparam logic [11:0] ADDR_CFG_W0     = 12'h034;
  localparam logic [11:0] ADDR_CFG_W1     = 12'h038;

  // ctrl bits
  localparam int unsigned CTRL_JUMP_BIT    = 0;
  localparam int unsigned CTRL_FCLR_BIT    = 1;
  localparam int unsigned CTRL_RECRST_BIT  = 2;
  localparam int unsigned CTRL_RUN_BIT     = 3;
  localparam logic [5:0]  START_STATE      = 6'h00;
  localparam logic [5:0]  JUMP_RST_VAL     = 6'h00;

  typedef enum logic [3:0] {
    SXR_LOAD   = 4'b0001,
    SXR_RUN    = 4'b0010,
    SXR_IDLE   = 4'b0100,
    SXR_HOLD   = 4'b1000
  } sxr_se_state_type;

  typedef enum logic [3:0] {
    REC_SCAN  = 4'b0001,
    REC_READY = 4'b0010,
    REC_PROG  = 4'b0100,
    REC_FULL  = 4'b1000
  } sxr_rec_state_type;

  // exit cause codes
  localparam logic [1:0] EXIT_NONE = 2'h0;
  localparam logic [1:0] EXIT_SEQ  = 2'h1;
  localparam logic [1:0] EXIT_TMO  = 2'h2;
  localparam logic [1:0] EXIT_MON  = 2'h3;

  // per-state definition, two 32-bit words
  typedef struct packed {
    logic [3:0]  seq_sel;      // which se input
    logic        seq_level;    // target level
    logic [5:0]  seq_next;
    logic [5:0]  tmo_next;
    logic [5:0]  mon_next;
    logic        tmo_en;
    logic        flt_latch_en;
    logic        rec_write;
    logic [5:0]  rsvd;
  } sxr_cfg0_type;

  typedef struct packed {
    logic [9:0]  drv_level;    // driver output levels
    logic [11:0] mon_mask;     // enabled inputs for monitor OR
    logic [9:0]  mon_expect_hi;// expected level for supply inputs
  } sxr_cfg1_type;

  typedef struct packed {
    logic [18:0] seq_delay_us; // 0 = no delay
    logic [18:0] tmo_delay_us;
  } sxr_cfg2_type;

  typedef struct packed {
    logic [9:0] uv;
    logic [9:0] ov;
    logic [4:0] gpi;
    logic [9:0] lim;
  } sxr_status_type;
endpackage

//--- sim/sxr_core_monitor.sv
`timescale 1ns/10ps
module sxr_core_monitor
  import sxr_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // bus handshake
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic [9:0]  driver_output_pin,
  input wire logic        nv_rd,
  input wire logic        nv_wr,
  input wire logic [15:0] nv_addr,
  input wire logic [7:0]  nv_wdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] wr_gap_reg;
  logic [15:0] drv_gap_reg;
  logic [15:0] last_wr_reg;
  //////////////////////////////////////////////////////////////////////
  // gaps saturate so a long idle spell never wraps into a short one
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) wr_gap_reg <= 16'hffff;
    else if (nv_wr) wr_gap_reg <= 16'h0000;
    else if (wr_gap_reg != 16'hffff) wr_gap_reg <= wr_gap_reg + 16'h0001;
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) drv_gap_reg <= 16'hffff;
    else if ($changed(driver_output_pin)) drv_gap_reg <= 16'h0000;
    else if (drv_gap_reg != 16'hffff) drv_gap_reg <= drv_gap_reg + 16'h0001;
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) last_wr_reg <= 16'h0000;
    else if (nv_wr) last_wr_reg <= nv_addr;
  //////////////////////////////////////////////////////////////////////
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_wr_region: assert property (nv_wr |-> nv_addr >= REC_BASE && nv_addr <= USER_NV_LAST)
    else $error("record write outside region");
  a_scan_slot: assert property (nv_rd |-> nv_addr[2:0] == 3'h0 && nv_addr >= REC_BASE
    && nv_addr <= REC_LAST_SLOT)
    else $error("scan read off slot grid");
  a_flag_clear: assert property (nv_wr && nv_addr[2:0] == 3'h0 |-> !nv_wdata[7])
    else $error("record flag not cleared");
  a_byte_order: assert property (nv_wr && nv_addr[2:0] != 3'h0
    |-> nv_addr == last_wr_reg + 16'h0001)
    else $error("record bytes out of order");
  a_byte_gap: assert property (nv_wr |-> wr_gap_reg >= 16'(BYTE_PROG_CYC - 1))
    else $error("record bytes too close");
  a_drv_hold: assert property ($changed(driver_output_pin) |-> drv_gap_reg >= 16'(LOAD_CYC - 1))
    else $error("driver outputs changed within a state");
  a_drv_settle: assert property ($changed(driver_output_pin)
    |=> $stable(driver_output_pin) [*8])
    else $error("driver outputs not settled");
  c_record: cover property (nv_wr);
  c_refused: cover property (pslverr);
  c_state: cover property ($changed(driver_output_pin));
endmodule // sxr_core_monitor

//--- sim/sxr_nv_model.sv
`timescale 1ns/10ps
module sxr_nv_model
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        slow,
  // memory port
  input  wire logic        nv_rd,
  input  wire logic        nv_wr,
  input  wire logic [15:0] nv_addr,
  input  wire logic [7:0]  nv_wdata,
  output logic      [7:0]  nv_rdata,
  output logic             nv_rvalid
);
  logic [7:0]  mem [16'hf900:16'hf9ff];
  logic [15:0] ra;
  logic [4:0]  cnt;
  // region erased before use, two slots already used
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    mem[16'hf980] = 8'h00;
    mem[16'hf988] = 8'h00;
  end
  // programming only clears bits
  always @(posedge ref_clk)
    if (nv_wr) mem[nv_addr] <= mem[nv_addr] & nv_wdata;
  // idle data toggles so a stale byte never looks valid
  always @(posedge ref_clk or negedge rstn)
  begin
    nv_rvalid <= 1'b0;
    if (!rstn) cnt <= 5'h00;
    else if (nv_rd)
    begin
      ra <= nv_addr;
      cnt <= slow ? 5'h14 : 5'h02;
    end
    else if (cnt == 5'h01)
    begin
      nv_rvalid <= 1'b1;
      nv_rdata <= mem[ra];
      cnt <= 5'h00;
    end
    else
    begin
      nv_rdata <= (nv_rdata === 8'hxx) ? 8'h5a : ~nv_rdata;
      if (cnt != 5'h00) cnt <= cnt - 5'h01;
    end
  end
endmodule // sxr_nv_model

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import sxr_pkg::*;
  logic        ref_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, slow = 1'b0, rerr;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat, tmp;
  logic [9:0]  uv = 10'h000, ov = 10'h000, lim = 10'h000, driver_output_pin;
  logic        warn = 1'b1, nv_rd, nv_wr, nv_rvalid, wr_seen = 1'b0;
  logic [15:0] nv_addr, wr_addr0 = 16'h0000;
  logic [7:0]  nv_wdata, nv_rdata;
  int          err_count = 0, samples_checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  sxr_core sxr_core_inst (.ref_clk, .rstn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .supply_fault_detector_uv(uv), .supply_fault_detector_ov(ov),
    .adc_limit_warn(lim), .secondary_warn(warn), .driver_output_pin, .nv_rd, .nv_wr, .nv_addr,
    .nv_wdata, .nv_rdata, .nv_rvalid);
  sxr_nv_model sxr_nv_model_inst (.ref_clk, .rstn, .slow, .nv_rd, .nv_wr, .nv_addr, .nv_wdata,
    .nv_rdata, .nv_rvalid);
  always @(posedge ref_clk)
    if (nv_wr && !wr_seen)
    begin
      wr_addr0 <= nv_addr;
      wr_seen <= 1'b1;
    end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(n, rdat, exp);
  endtask
  task automatic cfg(input logic [5:0] i, input sxr_cfg0_type c0, input sxr_cfg1_type c1,
                     input logic [18:0] dl);
    apb(1'b1, ADDR_CFG_SEL, {1'b1, 5'h00, i, 1'b0, dl});
    apb(1'b1, ADDR_CFG_W0, c0);
    apb(1'b1, ADDR_CFG_W1, c1);
  endtask
  // waits for the new state's outputs and bounds the time taken
  task automatic wdrv(input logic [9:0] e, input int lo, input int hi);
    int n;
    n = 0;
    while (driver_output_pin !== e && n < hi)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("driver_output_pin", 32'(driver_output_pin), 32'(e));
    chk("exit_time", 32'(n >= lo), 32'h1);
  endtask
  task automatic flt(input logic [31:0] exp);
    apb(1'b0, ADDR_FLT_LOW, 32'h0);
    tmp = rdat;
    apb(1'b0, ADDR_FLT_HIGH, 32'h0);
    chk("fault_latch", 32'((tmp | rdat) != 32'h0), exp);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(30000);
    err_count++;
    $display("watchdog expired");
    summarize();
  end
  initial
  begin
    cyc(20);
    rstn <= 1'b1;
    cyc(40);
    rchk("rec_status", ADDR_REC_STAT, 32'h22);
    apb(1'b0, 12'h040, 32'h0);
    chk("slverr", 32'(rerr), 32'h1);
    uv <= 10'h2a5;
    ov <= 10'h11a;
    lim <= 10'h155;
    cyc(4);
    rchk("uv", ADDR_UV_STATUS, 32'h2a5);
    rchk("ov", ADDR_OV_STATUS, 32'h11a);
    rchk("logic_in", ADDR_LOGIC_STAT, 32'h15);
    rchk("limits", ADDR_LIM_STATUS, 32'h155);
    uv <= 10'h000;
    ov <= 10'h000;
    lim <= 10'h000;
    cfg(6'h00, '{4'ha, 1'b0, 6'h01, 6'h01, 6'h01, 1'b0, 1'b1, 1'b0, 6'h00}, 32'h00400000, 19'd10);
    cfg(6'h01, '{4'hb, 1'b1, 6'h03, 6'h03, 6'h02, 1'b0, 1'b0, 1'b0, 6'h00}, 32'h00900000, 19'd0);
    cfg(6'h02, '{4'hb, 1'b1, 6'h03, 6'h03, 6'h03, 1'b1, 1'b0, 1'b1, 6'h00}, 32'h01000000, 19'd100);
    cfg(6'h03, '{4'hb, 1'b1, 6'h05, 6'h05, 6'h05, 1'b0, 1'b0, 1'b0, 6'h00}, 32'h02000000, 19'd0);
    cfg(6'h05, '{4'hb, 1'b1, 6'h05, 6'h05, 6'h05, 1'b0, 1'b0, 1'b0, 6'h00}, 32'hffc00000, 19'd0);
    apb(1'b1, ADDR_CTRL, 32'h8);
    wdrv(10'h001, 780, 840);
    uv <= 10'h001;
    cyc(10);
    uv <= 10'h000;
    flt(32'h1);
    warn <= 1'b0;
    cyc(200);
    warn <= 1'b1;
    cyc(10);
    warn <= 1'b0;
    wdrv(10'h002, 1150, 1300);
    lim <= 10'h008;
    uv <= 10'h0f0;
    wdrv(10'h004, 795, 830);
    lim <= 10'h000;
    uv <= 10'h000;
    rchk("snapshot", ADDR_SNAP0, 32'h3c000);
    wdrv(10'h008, 4700, 4900);
    apb(1'b1, ADDR_CTRL, 32'ha);
    uv <= 10'h001;
    cyc(10);
    uv <= 10'h000;
    flt(32'h0);
    apb(1'b1, ADDR_CTRL, 32'h9);
    wdrv(10'h3ff, 780, 840);
    chk("record_slot", 32'(wr_addr0), 32'hf990);
    chk("record_flag", 32'(sxr_nv_model_inst.mem[16'hf990][7]), 32'h0);
    rstn <= 1'b0;
    for (int s = 0; s < 16; s++) sxr_nv_model_inst.mem[16'hf980 + 16'(8 * s)] = 8'h00;
    slow <= 1'b1;
    cyc(20);
    rstn <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h4);
    cyc(600);
    apb(1'b0, ADDR_REC_STAT, 32'h0);
    chk("rec_full", 32'(rdat[7:4]), 32'h8);
    summarize();
  end
endmodule // tb_top
bind sxr_core sxr_core_monitor sxr_core_monitor_inst (.ref_clk, .rstn, .psel, .penable, .pready,
  .pslverr, .driver_output_pin, .nv_rd, .nv_wr, .nv_addr, .nv_wdata);
